//--- logic/dbw_pkg.sv
`default_nettype none

package dbw_pkg;

    // ********************************************************
    // Word and byte geometry
    // ********************************************************
    localparam int unsigned DBW_BYTE_W      = 9;
    localparam int unsigned DBW_WIDTH_X18   = 18;
    localparam int unsigned DBW_ADDR_W_X18  = 19;
    localparam int unsigned DBW_MAX_W       = 36;
    localparam int unsigned DBW_MAX_BYTES   = 4;
    localparam int unsigned DBW_MAX_IDX_W   = 21;

    // ********************************************************
    // Pipeline depths in input-clock rises; buffer depth in entries
    // ********************************************************
    localparam int unsigned DBW_WR_STAGES   = 3;
    localparam int unsigned DBW_RD_STAGES   = 5;
    localparam int unsigned DBW_BUF_DEPTH   = 2;

    // ********************************************************
    // Values after reset
    // ********************************************************
    localparam logic        DBW_PHASE_RST   = 1'b1;
    localparam logic        DBW_OE_N_RST    = 1'b1;
    localparam logic        DBW_RDY_RST     = 1'b1;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [1:0] {
        DBW_OP_NOP   = 2'b00,
        DBW_OP_WRITE = 2'b01,
        DBW_OP_READ  = 2'b10
    } dbw_op_t;

    typedef struct packed {
        logic [DBW_MAX_IDX_W-1:0] index;
        logic [DBW_MAX_BYTES-1:0] sel_n;
        logic [DBW_MAX_W-1:0]     data;
    } dbw_beat_t;

endpackage

`default_nettype wire

//--- logic/dbw_byte_en.sv
`timescale 1ns/100ps
`default_nettype none

module dbw_byte_en #(
    parameter int unsigned BYTES  = 2,
    parameter int unsigned BYTE_W = 9
) (
    // Active-low selects of one beat
    input  wire logic [BYTES-1:0]        sel_n,
    // Bit-level write enable
    output logic      [BYTES*BYTE_W-1:0] mask
);

    for (genvar i = 0; i < BYTES; i++) begin : g_lane
        assign mask[i*BYTE_W +: BYTE_W] = {BYTE_W{~sel_n[i]}};
    end

endmodule

`default_nettype wire

//--- logic/dbw_buf.sv
`timescale 1ns/100ps
`default_nettype none

module dbw_buf #(
    parameter int unsigned W     = 8,
    parameter int unsigned DEPTH = 2
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // Filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);

    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] ent;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [CW-1:0]           cnt;
        logic                    in_rdy;
    } dbw_buf_state_t;

    dbw_buf_state_t s_r;
    dbw_buf_state_t s_nxt;
    logic           push;
    logic           pop;

    assign push      = in_valid && s_r.in_rdy;
    assign pop       = out_ready && (s_r.cnt != '0);
    assign in_ready  = s_r.in_rdy;
    assign out_valid = (s_r.cnt != '0);
    assign out_data  = s_r.ent[s_r.rp];

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.ent[s_r.wp] = in_data;
            s_nxt.wp = (s_r.wp == PW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
        end
        if (pop) begin
            s_nxt.rp = (s_r.rp == PW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
        end
        s_nxt.cnt    = s_r.cnt + CW'(push) - CW'(pop);
        s_nxt.in_rdy = (s_nxt.cnt != CW'(DEPTH));
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r        <= '0;
            s_r.in_rdy <= dbw_pkg::DBW_RDY_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

`default_nettype wire

//--- logic/dbw_write_path.sv
// Behaviour
// - x18: both selects low write all bits 17..0 of the beat.
// - x18: select 0 low only writes bits 8..0, keeps 17..9.
// - x18: select 1 low only writes bits 17..9, keeps 8..0.
// - x18: both selects high leave the word untouched.
// - x36: all four selects low write all 36 bits.
// - x36: select 0 alone low writes bits 8..0 only.
// - x36: select 1 alone low writes bits 17..9 only.
// - x36: select 2 alone low writes bits 26..18 only.
// - x36: select 3 alone low writes bits 35..27 only.
// - x36: all selects high write nothing for that beat.
// - Selects are sampled separately for each beat of a burst.
// - Write data is registered on true and complement clock rises.
// - Read data launches on true and complement clock rises.
// - After power-up the device is deselected, outputs tri-stated.
// - First beat uses the latched address, second beat the next one.
// - Cycle t starts an operation; write beats follow at t+2, t+3, read data at t+5, t+6.
// - Write: load and rw low on true rise, beats at t+2 and t+3.
// - Selects travel with each data word; deasserted keeps the byte.
`timescale 1ns/100ps
`default_nettype none

module dbw_write_path #(
    parameter int unsigned WIDTH  = dbw_pkg::DBW_WIDTH_X18,
    parameter int unsigned ADDR_W = dbw_pkg::DBW_ADDR_W_X18
) (
    // Clock and reset; each clk rise is one input-clock rise
    input  wire logic                                  clk,
    input  wire logic                                  reset,
    // Controls, sampled on true-clock rises
    input  wire logic                                  load_n,
    input  wire logic                                  rw_n,
    input  wire logic [ADDR_W-1:0]                     addr,
    // Write beat
    input  wire logic [WIDTH/dbw_pkg::DBW_BYTE_W-1:0]  byte_write_select_n,
    input  wire logic [WIDTH-1:0]                      wdata,
    // Read data and its enable
    output logic      [WIDTH-1:0]                      rdata,
    output logic                                       rdata_oe_n,
    // Status
    output logic                                       phase_true,
    output logic                                       write_accept
);

    localparam int unsigned BYTES = WIDTH / dbw_pkg::DBW_BYTE_W;
    localparam int unsigned IW    = ADDR_W + 1;
    localparam int unsigned WS    = dbw_pkg::DBW_WR_STAGES;
    localparam int unsigned RS    = dbw_pkg::DBW_RD_STAGES;
    localparam int unsigned MW    = dbw_pkg::DBW_MAX_W;

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic                       phase_true;
        logic [WS-1:0]              wsh;
        logic [WS-1:0][ADDR_W-1:0]  wa;
        logic [RS-1:0]              rsh;
        logic [RS-1:0][ADDR_W-1:0]  ra;
        logic [WIDTH-1:0]           rdata;
        logic                       rdata_oe_n;
    } dbw_state_t;

    dbw_state_t         s_r;
    dbw_state_t         s_nxt;
    dbw_pkg::dbw_op_t   op;
    dbw_pkg::dbw_beat_t beat_in;
    dbw_pkg::dbw_beat_t beat_out;
    logic               beat_valid;
    logic               buf_ready;
    logic               drain_valid;
    logic               drain_ready;
    logic               drain_fire;
    logic [IW-1:0]      drain_idx;
    logic [WIDTH-1:0]   drain_mask;
    logic [WIDTH-1:0]   mem [2**IW];

    // ********************************************************
    // Command decode on true-clock rises
    // ********************************************************
    always_comb begin
        op = dbw_pkg::DBW_OP_NOP;
        if (s_r.phase_true && !load_n) begin
            case (rw_n)
                1'b0:    op = dbw_pkg::DBW_OP_WRITE;
                1'b1:    op = dbw_pkg::DBW_OP_READ;
                default: op = dbw_pkg::DBW_OP_NOP;
            endcase
        end
    end

    // ********************************************************
    // Beat capture into the buffer
    // ********************************************************
    always_comb begin
        beat_in            = '0;
        beat_in.sel_n      = '1;
        beat_valid         = s_r.wsh[1] || s_r.wsh[2];
        beat_in.data[WIDTH-1:0]  = wdata;
        beat_in.sel_n[BYTES-1:0] = byte_write_select_n;
        if (s_r.wsh[1]) begin
            beat_in.index[IW-1:0] = {s_r.wa[1], 1'b0};
        end else begin
            beat_in.index[IW-1:0] = {s_r.wa[2], 1'b1};
        end
    end

    dbw_buf #(
        .W     ($bits(dbw_pkg::dbw_beat_t)),
        .DEPTH (dbw_pkg::DBW_BUF_DEPTH)
    ) u_buf (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (beat_valid),
        .in_ready  (buf_ready),
        .in_data   (beat_in),
        .out_valid (drain_valid),
        .out_ready (drain_ready),
        .out_data  (beat_out)
    );

    // ********************************************************
    // Array write with byte enables
    // ********************************************************
    dbw_byte_en #(
        .BYTES  (BYTES),
        .BYTE_W (dbw_pkg::DBW_BYTE_W)
    ) u_byte_en (
        .sel_n (beat_out.sel_n[BYTES-1:0]),
        .mask  (drain_mask)
    );

    // Array port is busy while a read launches
    assign drain_ready = !(s_r.rsh[3] || s_r.rsh[4]);
    assign drain_fire  = drain_valid && drain_ready;
    assign drain_idx   = beat_out.index[IW-1:0];

    always_ff @(posedge clk) begin
        if (drain_fire) begin
            mem[drain_idx] <= (mem[drain_idx] & ~drain_mask)
                            | (beat_out.data[WIDTH-1:0] & drain_mask);
        end
    end

    // ********************************************************
    // Pipelines, phase and read launch
    // ********************************************************
    always_comb begin
        s_nxt            = s_r;
        s_nxt.phase_true = !s_r.phase_true;
        s_nxt.wsh = {s_r.wsh[WS-2:0], op == dbw_pkg::DBW_OP_WRITE};
        s_nxt.wa  = {s_r.wa[WS-2:0], addr};
        s_nxt.rsh = {s_r.rsh[RS-2:0], op == dbw_pkg::DBW_OP_READ};
        s_nxt.ra  = {s_r.ra[RS-2:0], addr};
        s_nxt.rdata_oe_n = 1'b1;
        if (s_r.rsh[3]) begin
            s_nxt.rdata      = mem[{s_r.ra[3], 1'b0}];
            s_nxt.rdata_oe_n = 1'b0;
        end else if (s_r.rsh[4]) begin
            s_nxt.rdata      = mem[{s_r.ra[4], 1'b1}];
            s_nxt.rdata_oe_n = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r            <= '0;
            s_r.phase_true <= dbw_pkg::DBW_PHASE_RST;
            s_r.rdata_oe_n <= dbw_pkg::DBW_OE_N_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata        = s_r.rdata;
    assign rdata_oe_n   = s_r.rdata_oe_n;
    assign phase_true   = s_r.phase_true;
    assign write_accept = buf_ready;

    // ********************************************************
    // Checks
    // ********************************************************
    logic                         chk_v;
    logic [IW-1:0]                chk_idx;
    logic [MW-1:0]                chk_old;
    logic [MW-1:0]                chk_new;
    logic [dbw_pkg::DBW_MAX_BYTES-1:0] chk_sel;
    logic [MW-1:0]                chk_now;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            chk_v   <= 1'b0;
            chk_idx <= '0;
            chk_old <= '0;
            chk_new <= '0;
            chk_sel <= '1;
        end else begin
            chk_v   <= drain_fire;
            chk_idx <= drain_idx;
            chk_old <= MW'(mem[drain_idx]);
            chk_new <= beat_out.data;
            chk_sel <= beat_out.sel_n;
        end
    end

    assign chk_now = MW'(mem[chk_idx]);

    a_full_word18: assert property (@(posedge clk) disable iff (reset)
        chk_v && WIDTH == 18 && chk_sel[1:0] == 2'b00 |-> chk_now[17:0] == chk_new[17:0])
        else $error("x18 full write lost bits");
    a_low_byte18: assert property (@(posedge clk) disable iff (reset)
        chk_v && WIDTH == 18 && chk_sel[1:0] == 2'b10
        |-> chk_now[8:0] == chk_new[8:0] && chk_now[17:9] == chk_old[17:9])
        else $error("x18 lower byte write wrong");
    a_high_byte18: assert property (@(posedge clk) disable iff (reset)
        chk_v && WIDTH == 18 && chk_sel[1:0] == 2'b01
        |-> chk_now[17:9] == chk_new[17:9] && chk_now[8:0] == chk_old[8:0])
        else $error("x18 upper byte write wrong");
    a_no_write18: assert property (@(posedge clk) disable iff (reset)
        chk_v && WIDTH == 18 && chk_sel[1:0] == 2'b11 |-> chk_now[17:0] == chk_old[17:0])
        else $error("x18 masked beat changed word");
    a_full_word36: assert property (@(posedge clk) disable iff (reset)
        chk_v && WIDTH == 36 && chk_sel == 4'h0 |-> chk_now == chk_new)
        else $error("x36 full write lost bits");
    a_byte0_36: assert property (@(posedge clk) disable iff (reset)
        chk_v && WIDTH == 36 && chk_sel == 4'hE
        |-> chk_now[8:0] == chk_new[8:0] && chk_now[35:9] == chk_old[35:9])
        else $error("x36 byte 0 write wrong");
    a_byte1_36: assert property (@(posedge clk) disable iff (reset)
        chk_v && WIDTH == 36 && chk_sel == 4'hD
        |-> chk_now[17:9] == chk_new[17:9] && chk_now[8:0] == chk_old[8:0]
            && chk_now[35:18] == chk_old[35:18])
        else $error("x36 byte 1 write wrong");
    a_byte2_36: assert property (@(posedge clk) disable iff (reset)
        chk_v && WIDTH == 36 && chk_sel == 4'hB
        |-> chk_now[26:18] == chk_new[26:18] && chk_now[17:0] == chk_old[17:0]
            && chk_now[35:27] == chk_old[35:27])
        else $error("x36 byte 2 write wrong");
    a_byte3_36: assert property (@(posedge clk) disable iff (reset)
        chk_v && WIDTH == 36 && chk_sel == 4'h7
        |-> chk_now[35:27] == chk_new[35:27] && chk_now[26:0] == chk_old[26:0])
        else $error("x36 byte 3 write wrong");
    a_no_write36: assert property (@(posedge clk) disable iff (reset)
        chk_v && WIDTH == 36 && chk_sel == 4'hF |-> chk_now == chk_old)
        else $error("x36 masked beat changed word");
    a_first_beat: assert property (@(posedge clk) disable iff (reset)
        op == dbw_pkg::DBW_OP_WRITE |-> ##2 beat_valid && s_r.phase_true
            && beat_in.index[IW-1:0] == {$past(addr, 2), 1'b0})
        else $error("first write beat misplaced");
    a_second_beat: assert property (@(posedge clk) disable iff (reset)
        op == dbw_pkg::DBW_OP_WRITE |-> ##3 beat_valid
            && beat_in.index[IW-1:0] == {$past(addr, 3), 1'b1})
        else $error("second write beat misplaced");
    a_read_launch: assert property (@(posedge clk) disable iff (reset)
        op == dbw_pkg::DBW_OP_READ |-> ##5 !rdata_oe_n ##1 !rdata_oe_n)
        else $error("read data not launched on time");
    a_idle_tristate: assert property (@(posedge clk) disable iff (reset)
        s_r.rsh[4:3] == 2'b00 |=> rdata_oe_n)
        else $error("output driven with no read");

endmodule

`default_nettype wire

//--- testbench/dbw_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none

module dbw_ctl_model #(
    parameter int unsigned WIDTH  = 18,
    parameter int unsigned ADDR_W = 4
) (
    // Clock and phase seen from the device
    input  wire logic                                 clk,
    input  wire logic                                 phase_true,
    // Controls
    output logic                                      load_n,
    output logic                                      rw_n,
    output logic      [ADDR_W-1:0]                    addr,
    // Write beat
    output logic      [WIDTH/dbw_pkg::DBW_BYTE_W-1:0] byte_write_select_n,
    output logic      [WIDTH-1:0]                     wdata
);
    localparam int unsigned NB = WIDTH / dbw_pkg::DBW_BYTE_W;

    typedef struct packed {
        logic              start;
        logic              load_n;
        logic              rw_n;
        logic              beat;
        logic [3:0]        sel_n;
        logic [35:0]       data;
        logic [ADDR_W-1:0] addr;
    } dbw_slot_t;

    localparam dbw_slot_t SLOT_IDLE = '{load_n: 1'b1, default: '0};

    dbw_slot_t slots[$];
    dbw_slot_t cur;
    logic      go;

    initial begin
        {load_n, rw_n, addr, byte_write_select_n, wdata} = '1;
    end

    // ********************************************************
    // One slot per clock; idle lines other than load_n invert so nothing stale lingers; load_n is held high
    // ********************************************************
    always @(posedge clk) begin
        #1;
        go = slots.size() != 0 && (!slots[0].start || phase_true === 1'b1);
        cur = go ? slots.pop_front() : SLOT_IDLE;
        load_n <= cur.load_n;
        rw_n <= cur.start ? cur.rw_n : ~rw_n;
        addr <= cur.start ? cur.addr : ~addr;
        byte_write_select_n <= cur.beat ? cur.sel_n[NB-1:0] : ~byte_write_select_n;
        wdata <= cur.beat ? cur.data[WIDTH-1:0] : ~wdata;
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [1:0][35:0] d,
                      input logic [1:0][3:0] s);
        slots.push_back('{start: 1'b1, load_n: 1'b0, rw_n: 1'b0, addr: a, default: '0});
        slots.push_back(SLOT_IDLE);
        for (int b = 0; b < 2; b++) begin
            slots.push_back('{beat: 1'b1, load_n: 1'b1, sel_n: s[b], data: d[b], default: '0});
        end
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        slots.push_back('{start: 1'b1, load_n: 1'b0, rw_n: 1'b1, addr: a, default: '0});
    endtask
endmodule

`default_nettype wire

//--- testbench/ddr_sram_byte_write_path_test.sv
`timescale 1ns/100ps
`default_nettype none

module ddr_sram_byte_write_path_test;
    localparam int AW = 4;

    logic        clk;
    logic        reset;
    logic        ld18, rw18, oe18, ph18, wa18, ld36, rw36, oe36, ph36, wa36;
    logic [3:0]  ad18, ad36, sel36;
    logic [1:0]  sel18;
    logic [17:0] wd18, rd18;
    logic [35:0] wd36, rd36;
    logic [35:0] m18[int], m36[int], q18[$], q36[$];
    logic [5:0]  rd_hist = '0;
    logic [5:0]  wr_hist = '0;
    logic        pb, wab;
    int          fails, checked, cycles, k, a;
    int          seed = 8034;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk; // Never stopped, so no park level is owed
    end

    dbw_write_path #(.WIDTH(18), .ADDR_W(AW)) uut (.clk(clk), .reset(reset),
        .load_n(ld18), .rw_n(rw18), .addr(ad18), .byte_write_select_n(sel18), .wdata(wd18),
        .rdata(rd18), .rdata_oe_n(oe18), .phase_true(ph18), .write_accept(wa18));
    dbw_write_path #(.WIDTH(36), .ADDR_W(AW)) uut36 (.clk(clk), .reset(reset),
        .load_n(ld36), .rw_n(rw36), .addr(ad36), .byte_write_select_n(sel36), .wdata(wd36),
        .rdata(rd36), .rdata_oe_n(oe36), .phase_true(ph36), .write_accept(wa36));
    dbw_ctl_model #(.WIDTH(18), .ADDR_W(AW)) ctl18 (.clk(clk), .phase_true(ph18),
        .load_n(ld18), .rw_n(rw18), .addr(ad18), .byte_write_select_n(sel18), .wdata(wd18));
    dbw_ctl_model #(.WIDTH(36), .ADDR_W(AW)) ctl36 (.clk(clk), .phase_true(ph36),
        .load_n(ld36), .rw_n(rw36), .addr(ad36), .byte_write_select_n(sel36), .wdata(wd36));

    // ********************************************************
    // Compare, model and stimulus helpers
    // ********************************************************
    task automatic chk_d(input logic [35:0] exp, input logic [35:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: expected %h, got %h", $time, exp, got);
        end
    endtask

    task automatic chk_f(input logic exp, input logic got);
        chk_d({35'h0, exp}, {35'h0, got});
    endtask

    function automatic logic [35:0] rnd();
        logic [63:0] r;
        r = {$random(seed), $random(seed)};
        return r[35:0];
    endfunction

    function automatic logic [35:0] mrg(input logic [35:0] old, input logic [35:0] d,
                                        input logic [3:0] s, input int nb);
        for (int i = 0; i < nb; i++) begin
            if (s[i] === 1'b0) begin
                old[i*9 +: 9] = d[i*9 +: 9];
            end
        end
        return old;
    endfunction

    task automatic idle(input int n);
        for (int i = 0; i < 400 && ctl18.slots.size() != 0; i++) @(posedge clk);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input int a, input logic [1:0][35:0] d, input logic [1:0][3:0] s);
        int x;
        ctl18.wr(a[AW-1:0], d, s);
        ctl36.wr(a[AW-1:0], d, s);
        for (int b = 0; b < 2; b++) begin
            x = 2 * a + b;
            m18[x] = mrg(m18.exists(x) ? m18[x] : 36'h0, d[b], s[b], 2);
            m36[x] = mrg(m36.exists(x) ? m36[x] : 36'h0, d[b], s[b], 4);
        end
        idle(6);
    endtask

    task automatic rd(input int a);
        ctl18.rd(a[AW-1:0]);
        ctl36.rd(a[AW-1:0]);
        for (int b = 0; b < 2; b++) begin
            q18.push_back(m18[2 * a + b]);
            q36.push_back(m36[2 * a + b]);
        end
    endtask

    task automatic results();
        $display("checked %0d, fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ********************************************************
    // Per-cycle monitor: output enable window, phase, beats, data
    // ********************************************************
    always @(posedge clk) begin
        rd_hist <= {rd_hist[4:0], ph18 & ~ld18 & rw18};
        wr_hist <= {wr_hist[4:0], ph18 & ~ld18 & ~rw18};
        pb = ph18;
        wab = wa18 & wa36;
        if (!reset) begin
            #1;
            chk_f(~pb, ph18);
            chk_f(~(rd_hist[4] | rd_hist[5]), oe18);
            chk_f(~(rd_hist[4] | rd_hist[5]), oe36);
            if (wr_hist[2] | wr_hist[3]) chk_f(1'b1, wab);
            if (oe18 === 1'b0 && q18.size() != 0) chk_d(q18.pop_front(), {18'h0, rd18});
            if (oe36 === 1'b0 && q36.size() != 0) chk_d(q36.pop_front(), rd36);
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            results();
        end
    end

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        reset = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk_f(1'b1, oe18 & oe36);
        chk_f(1'b1, ph18 & ph36);
        repeat (3) @(posedge clk);
        #1;
        reset = 1'b0;
        for (a = 0; a < 16; a++)
            wr(a, {rnd(), rnd()}, 8'h00);
        for (a = 0; a < 16; a++)
            rd(a);
        idle(8);
        $display("test 1 done: full writes and back-to-back reads");
        for (k = 0; k < 16; k++)
            wr(k, {rnd(), rnd()}, {~k[3:0], k[3:0]});
        for (a = 0; a < 16; a++)
            rd(a);
        idle(8);
        $display("test 2 done: every select pattern on both beats");
        rd(3);
        idle(3);
        wr(3, {rnd(), rnd()}, 8'hF0);
        rd(3);
        idle(8);
        $display("test 3 done: read, write, read on one address");
        @(posedge clk);
        #1;
        reset = 1'b1;
        @(posedge clk);
        #1;
        chk_f(1'b1, oe18 & oe36 & ph18 & ph36);
        reset = 1'b0;
        rd(9);
        idle(8);
        $display("test 4 done: reset in mid-run keeps the array");
        results();
    end
endmodule

`default_nettype wire
